// *** design/iwd_timeout_guard.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - A host read of port 0x443 arms the guard and starts the countdown.
// - A host read of port 0x043 disarms the guard so no timeout can happen.
// - An armed guard whose period ends untriggered performs the chosen action.
// - The action select picks reset, NMI, or disables the guard when open.
// - The NMI setting drives the NMI output instead of the system reset.
// - The period select codes 2,3,4,5,8,9 give 1,2,10,20,110,220 seconds.
module iwd_timeout_guard
    import iwd_pkg::*;
#(
    parameter int unsigned CYC_PER_SEC = CLK_HZ
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire iwd_io_t IO_BUS,
    input wire logic [3:0] PERIOD_SELECT,
    input wire logic [1:0] ACTION_SELECT,
    output logic ARMED,
    output logic SYS_RESET,
    output logic NMI
);
    logic [3:0] per_s1_r, per_s2_r;
    logic [1:0] act_s1_r, act_s2_r;
    logic armed_r;
    logic [CNT_W-1:0] cnt_r;
    logic [4:0] rst_cnt_r;
    logic nmi_r;
    logic arm_hit, disarm_hit, expire, enabled;
    iwd_action_t act;

    // Jumper levels are asynchronous straps
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            per_s1_r <= 4'h0;
            per_s2_r <= 4'h0;
            act_s1_r <= 2'h0;
            act_s2_r <= 2'h0;
        end else begin
            per_s1_r <= PERIOD_SELECT;
            per_s2_r <= per_s1_r;
            act_s1_r <= ACTION_SELECT;
            act_s2_r <= act_s1_r;
        end
    end

    function automatic logic [CNT_W-1:0] period_cycles(input logic [3:0] sel);
        logic [CNT_W-1:0] secs;
        secs = CNT_ZERO;
        unique case (sel)
            PER_1S: secs = CNT_W'(T_1S);
            PER_2S: secs = CNT_W'(T_2S);
            PER_10S: secs = CNT_W'(T_10S);
            PER_20S: secs = CNT_W'(T_20S);
            PER_110S: secs = CNT_W'(T_110S);
            PER_220S: secs = CNT_W'(T_220S);
            default: secs = CNT_ZERO;
        endcase
        return CNT_W'(secs * CNT_W'(CYC_PER_SEC));
    endfunction

    assign act = iwd_action_t'(act_s2_r);
    // Unknown codes behave like an open jumper: safest choice
    assign enabled = (act == IWD_ACT_RESET) || (act == IWD_ACT_NMI);
    assign arm_hit = IO_BUS.rd && (IO_BUS.addr == ADDR_ARM);
    assign disarm_hit = IO_BUS.rd && (IO_BUS.addr == ADDR_DISARM);
    assign expire = armed_r && enabled && (cnt_r == CNT_ONE) && !arm_hit && !disarm_hit;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            armed_r <= 1'b0;
        end else if (disarm_hit || !enabled) begin
            armed_r <= 1'b0;
        end else if (arm_hit) begin
            armed_r <= 1'b1;
        end else if (expire) begin
            armed_r <= 1'b0;
        end
    end

    // Unlisted period codes give zero: arming sets ARMED but the guard never expires
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cnt_r <= CNT_ZERO;
        end else if (disarm_hit || !enabled) begin
            cnt_r <= CNT_ZERO;
        end else if (arm_hit) begin
            cnt_r <= period_cycles(per_s2_r);
        end else if (armed_r && cnt_r != CNT_ZERO) begin
            cnt_r <= cnt_r - CNT_ONE;
        end
    end

    // Reset is a pulse so the host sees a clean restart
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rst_cnt_r <= 5'h00;
        end else if (expire && act == IWD_ACT_RESET) begin
            rst_cnt_r <= 5'(RESET_PULSE_CYC);
        end else if (rst_cnt_r != 5'h00) begin
            rst_cnt_r <= rst_cnt_r - 5'h01;
        end
    end

    // NMI holds until the next arm or disarm read
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            nmi_r <= 1'b0;
        end else if (expire && act == IWD_ACT_NMI) begin
            nmi_r <= 1'b1;
        end else if (arm_hit || disarm_hit) begin
            nmi_r <= 1'b0;
        end
    end

    assign ARMED = armed_r;
    assign SYS_RESET = (rst_cnt_r != 5'h00);
    assign NMI = nmi_r;

    property p_arm;
        @(posedge CLK_SYS) disable iff (RST)
        (arm_hit && enabled && !disarm_hit) |=> armed_r;
    endproperty
    a_arm: assert property (p_arm) else $error("arm read did not arm");

    sequence s_quiet;
        !$rose(SYS_RESET) && !$rose(NMI);
    endsequence

    // A pulse already running may finish; only new actions are barred
    property p_disarm;
        @(posedge CLK_SYS) disable iff (RST)
        disarm_hit |=> !armed_r ##0 s_quiet ##1 s_quiet;
    endproperty
    a_disarm: assert property (p_disarm) else $error("disarm read failed");

    property p_reset_action;
        @(posedge CLK_SYS) disable iff (RST)
        (expire && act == IWD_ACT_RESET) |=> SYS_RESET && !NMI;
    endproperty
    a_reset_action: assert property (p_reset_action) else $error("no reset on timeout");

    sequence s_nmi_expire;
        expire && act == IWD_ACT_NMI;
    endsequence
    property p_nmi_action;
        @(posedge CLK_SYS) disable iff (RST)
        s_nmi_expire |=> NMI && !SYS_RESET;
    endproperty
    a_nmi_action: assert property (p_nmi_action) else $error("no NMI on timeout");

    property p_off;
        @(posedge CLK_SYS) disable iff (RST)
        (!enabled && !SYS_RESET) |=> !armed_r && !$rose(SYS_RESET) && !$rose(NMI);
    endproperty
    a_off: assert property (p_off) else $error("disabled guard acted");

    property p_reload;
        @(posedge CLK_SYS) disable iff (RST)
        (arm_hit && enabled && !disarm_hit) |=> cnt_r == period_cycles($past(per_s2_r));
    endproperty
    a_reload: assert property (p_reload) else $error("trigger did not reload");

    property p_period_1s;
        @(posedge CLK_SYS) disable iff (RST)
        (arm_hit && enabled && !disarm_hit && per_s2_r == PER_1S)
            |=> cnt_r == CNT_W'(T_1S) * CNT_W'(CYC_PER_SEC);
    endproperty
    a_period_1s: assert property (p_period_1s) else $error("1 s period wrong");

    property p_period_2s;
        @(posedge CLK_SYS) disable iff (RST)
        (arm_hit && enabled && !disarm_hit && per_s2_r == PER_2S)
            |=> cnt_r == CNT_W'(T_2S) * CNT_W'(CYC_PER_SEC);
    endproperty
    a_period_2s: assert property (p_period_2s) else $error("2 s period wrong");

    property p_period_10s;
        @(posedge CLK_SYS) disable iff (RST)
        (arm_hit && enabled && !disarm_hit && per_s2_r == PER_10S)
            |=> cnt_r == CNT_W'(T_10S) * CNT_W'(CYC_PER_SEC);
    endproperty
    a_period_10s: assert property (p_period_10s) else $error("10 s period wrong");

    property p_period_20s;
        @(posedge CLK_SYS) disable iff (RST)
        (arm_hit && enabled && !disarm_hit && per_s2_r == PER_20S)
            |=> cnt_r == CNT_W'(T_20S) * CNT_W'(CYC_PER_SEC);
    endproperty
    a_period_20s: assert property (p_period_20s) else $error("20 s period wrong");

    property p_period_110s;
        @(posedge CLK_SYS) disable iff (RST)
        (arm_hit && enabled && !disarm_hit && per_s2_r == PER_110S)
            |=> cnt_r == CNT_W'(T_110S) * CNT_W'(CYC_PER_SEC);
    endproperty
    a_period_110s: assert property (p_period_110s) else $error("110 s period wrong");

    property p_period_220s;
        @(posedge CLK_SYS) disable iff (RST)
        (arm_hit && enabled && !disarm_hit && per_s2_r == PER_220S)
            |=> cnt_r == CNT_W'(T_220S) * CNT_W'(CYC_PER_SEC);
    endproperty
    a_period_220s: assert property (p_period_220s) else $error("220 s period wrong");

    property p_pulse_len;
        @(posedge CLK_SYS) disable iff (RST)
        $rose(SYS_RESET) |-> SYS_RESET [*8];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too short");

    // Length of the running reset pulse, checked when it ends
    // A pulse cannot be stretched: the host is held in reset meanwhile
    logic [4:0] pulse_len_r;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pulse_len_r <= 5'h00;
        end else if (SYS_RESET) begin
            pulse_len_r <= pulse_len_r + 5'h01;
        end else begin
            pulse_len_r <= 5'h00;
        end
    end

    property p_pulse_total;
        @(posedge CLK_SYS) disable iff (RST)
        $fell(SYS_RESET) |-> pulse_len_r == 5'(RESET_PULSE_CYC);
    endproperty
    a_pulse_total: assert property (p_pulse_total) else $error("reset pulse length wrong");

    property p_nmi_hold;
        @(posedge CLK_SYS) disable iff (RST)
        (NMI && !arm_hit && !disarm_hit) |=> NMI;
    endproperty
    a_nmi_hold: assert property (p_nmi_hold) else $error("NMI dropped early");

    property p_no_early;
        @(posedge CLK_SYS) disable iff (RST)
        (armed_r && cnt_r > CNT_ONE) |=> s_quiet;
    endproperty
    a_no_early: assert property (p_no_early) else $error("action before period end");
endmodule // iwd_timeout_guard
`default_nettype wire

// *** design/iwd_pkg.sv ***
`default_nettype none
package iwd_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CNT_W = 33;
    localparam logic [15:0] ADDR_ARM = 16'h0443;
    localparam logic [15:0] ADDR_DISARM = 16'h0043;
    localparam logic [3:0] PER_1S = 4'h2;
    localparam logic [3:0] PER_2S = 4'h3;
    localparam logic [3:0] PER_10S = 4'h4;
    localparam logic [3:0] PER_20S = 4'h5;
    localparam logic [3:0] PER_110S = 4'h8;
    localparam logic [3:0] PER_220S = 4'h9;
    localparam int unsigned T_1S = 1;
    localparam int unsigned T_2S = 2;
    localparam int unsigned T_10S = 10;
    localparam int unsigned T_20S = 20;
    localparam int unsigned T_110S = 110;
    localparam int unsigned T_220S = 220;
    localparam int unsigned RESET_PULSE_CYC = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 33'h0_0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 33'h0_0000_0001;

    typedef enum logic [1:0] {
        IWD_ACT_OFF = 2'b00,
        IWD_ACT_RESET = 2'b01,
        IWD_ACT_NMI = 2'b10,
        IWD_ACT_BAD = 2'b11
    } iwd_action_t;

    typedef struct packed {
        logic rd;
        logic [15:0] addr;
    } iwd_io_t;
endpackage
`default_nettype wire

// *** sim/iwd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module iwd_host_model
    import iwd_pkg::*;
(
    input wire logic CLK_SYS,
    output var iwd_io_t IO_BUS
);
    initial IO_BUS = '{rd: 1'b0, addr: 16'hFFFF};
    // One-cycle read strobe; retrigger spacing is the caller's job
    task automatic io_read(input logic [15:0] a);
        @(posedge CLK_SYS);
        IO_BUS <= '{rd: 1'b1, addr: a};
        @(posedge CLK_SYS);
        IO_BUS <= '{rd: 1'b0, addr: ~a}; // Idle address moves, never stale
    endtask
endmodule // iwd_host_model
`default_nettype wire

// *** sim/io_port_watchdog_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module io_port_watchdog_tb
    import iwd_pkg::*;
;
    localparam int N = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] per = PER_1S;
    logic [1:0] act = IWD_ACT_OFF;
    iwd_io_t io;
    logic armed;
    logic sys_reset;
    logic nmi;
    int n_errors = 0;
    int n_checks = 0;
    int fires = 0;
    int n;
    logic [3:0] codes [6] = '{PER_1S, PER_2S, PER_10S, PER_20S, PER_110S, PER_220S};
    int secs [6] = '{T_1S, T_2S, T_10S, T_20S, T_110S, T_220S};
    iwd_timeout_guard #(.CYC_PER_SEC(N)) i_iwd_timeout_guard (.CLK_SYS(clk), .RST(rst),
        .IO_BUS(io), .PERIOD_SELECT(per), .ACTION_SELECT(act), .ARMED(armed),
        .SYS_RESET(sys_reset), .NMI(nmi));
    iwd_host_model i_iwd_host_model (.CLK_SYS(clk), .IO_BUS(io));
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge sys_reset or posedge nmi) fires++;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic setup(input logic [1:0] a, input logic [3:0] p);
        @(posedge clk);
        act <= a;
        per <= p;
        repeat (4) @(posedge clk); // Straps pass a two-flop synchroniser
    endtask
    task automatic arm_and_time(output int c);
        i_iwd_host_model.io_read(ADDR_ARM);
        c = 0;
        do begin
            @(negedge clk);
            c++;
            if (c == 3) check("armed", armed, 1'b1);
        end while (sys_reset !== 1'b1 && nmi !== 1'b1 && c < 3000);
    endtask
    task automatic t_periods;
        for (int i = 0; i < 6; i++) begin
            setup(IWD_ACT_RESET, codes[i]);
            arm_and_time(n);
            check("period", n >= secs[i] * N && n <= secs[i] * N + 1, 1);
            n = 0;
            while (sys_reset === 1'b1 && n < 100) begin
                @(negedge clk);
                n++;
            end
            check("pulse", n, RESET_PULSE_CYC);
            check("disarmed", armed, 1'b0);
        end
    endtask
    task automatic t_trigger;
        setup(IWD_ACT_RESET, PER_1S);
        n = fires;
        // Retrigger late in each period; four periods would have expired otherwise
        repeat (6) begin
            i_iwd_host_model.io_read(ADDR_ARM);
            repeat (N - 4) @(posedge clk);
        end
        check("reload", fires - n, 0);
        i_iwd_host_model.io_read(ADDR_DISARM);
        repeat (3 * N) @(negedge clk);
        check("disarm", {armed, 31'(fires - n)}, 0);
    endtask
    task automatic t_nmi;
        setup(IWD_ACT_NMI, PER_2S);
        arm_and_time(n);
        check("nmi time", n >= 2 * N && n <= 2 * N + 1, 1);
        repeat (30) @(negedge clk);
        check("nmi outs", {nmi, sys_reset}, 2'b10);
        i_iwd_host_model.io_read(ADDR_DISARM);
        repeat (2) @(negedge clk);
        check("nmi clear", nmi, 1'b0);
    endtask
    task automatic t_off;
        // Open strap and the spare code both leave the guard idle
        for (int k = 0; k < 2; k++) begin
            setup(k == 0 ? IWD_ACT_OFF : IWD_ACT_BAD, PER_1S);
            n = fires;
            i_iwd_host_model.io_read(ADDR_ARM);
            repeat (3 * N) @(negedge clk);
            check("off", {armed, 31'(fires - n)}, 0);
        end
    endtask
    task automatic t_unlisted;
        setup(IWD_ACT_RESET, 4'h0);
        n = fires;
        i_iwd_host_model.io_read(ADDR_ARM);
        repeat (3 * N) @(negedge clk);
        check("unlisted", {armed, 31'(fires - n)}, {1'b1, 31'h0000_0000});
        i_iwd_host_model.io_read(ADDR_DISARM);
        repeat (2) @(negedge clk);
        check("unlisted off", armed, 1'b0);
    endtask
    task automatic t_reset;
        setup(IWD_ACT_RESET, PER_1S);
        n = fires;
        i_iwd_host_model.io_read(ADDR_ARM);
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(negedge clk);
        check("reset mid", {armed, sys_reset, nmi}, 3'b000);
        @(posedge clk);
        rst <= 1'b0;
        repeat (3 * N) @(negedge clk);
        check("after reset", {armed, 31'(fires - n)}, 0);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        check("reset outs", {armed, sys_reset, nmi}, 3'b000);
        rst <= 1'b0;
        t_periods();
        t_trigger();
        t_nmi();
        t_unlisted();
        t_reset();
        t_off();
        tally_and_finish();
    end
    initial begin
        #1000000;
        n_errors++;
        tally_and_finish();
    end
endmodule // io_port_watchdog_tb
`default_nettype wire
